/* rtl/smbse_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smbse_params.svh"
module smbse_mem
   import smbse_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     ce,
   input  wire logic                     we,
   input  wire logic                     re,
   input  wire logic [`SMBSE_MEM_AW-1:0] addr,
   input  wire logic [7:0]               wdata,
   output logic      [7:0]               rdata
);
   // ****************************************
   // User storage
   // ****************************************
   logic [7:0] mem [0:`SMBSE_MEM_DEPTH-1];
   logic [7:0] rdata_q;

   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (ce && re) begin
         rdata_q <= mem[addr];
      end
   end

   assign rdata = rdata_q;
endmodule
`default_nettype wire

/* rtl/smbse_params.svh */
`ifndef SMBSE_PARAMS_SVH
`define SMBSE_PARAMS_SVH
// ****************************************
// Timing
// ****************************************
`define SMBSE_CLK_MHZ      40
`define SMBSE_STRETCH_US   1000
`define SMBSE_TIMEOUT_US   25000
`define SMBSE_LOWCNT_W     20
`define SMBSE_STRCNT_W     16
// ****************************************
// Addresses and limits
// ****************************************
`define SMBSE_CTL_ADDR     8'h20
`define SMBSE_EE_ADDR      8'hA0
`define SMBSE_EE_MASK      8'hF0
`define SMBSE_MAX_LEN      8'hFF
`define SMBSE_FILL_BYTE    8'hFF
`define SMBSE_MEM_AW       11
`define SMBSE_MEM_DEPTH    2048
`define SMBSE_EV_W         8
// ****************************************
// Pin synchroniser layout
// ****************************************
`define SMBSE_SYNC_W       5
`define SMBSE_SYNC_RST     5'h19
`define SMBSE_SY_SCL       4
`define SMBSE_SY_SDA       3
`define SMBSE_SY_PWR       2
`define SMBSE_SY_STBY      1
`define SMBSE_SY_WP        0
// ****************************************
// Bit engine
// ****************************************
`define SMBSE_BYTE_BITS    4'h8
`define SMBSE_LAST_BIT     4'h7
`define SMBSE_BLK_HI       3
`define SMBSE_BLK_LO       1
`endif

/* rtl/smbse_pkg.sv */
`include "smbse_params.svh"
package smbse_pkg;
   typedef enum logic {SMBSE_TGT_CTL, SMBSE_TGT_EE} smbse_tgt_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_WR, ST_ACK, ST_LOAD, ST_RD, ST_MACK, ST_SKIP
   } smbse_state_t;
   typedef struct packed {
      logic       strobe;
      logic       is_cmd;
      logic [7:0] data;
   } smbse_rx_t;
   typedef struct packed {
      logic       strobe;
      logic [7:0] count;
   } smbse_end_t;
   typedef struct packed {
      logic       strobe;
      logic [7:0] index;
   } smbse_rdreq_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } smbse_rdrsp_t;
endpackage

/* rtl/smbse_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smbse_params.svh"
module smbse_top
   import smbse_pkg::*;
#(
   parameter int STRETCH_CYC = `SMBSE_STRETCH_US * `SMBSE_CLK_MHZ,
   parameter int TIMEOUT_CYC = `SMBSE_TIMEOUT_US * `SMBSE_CLK_MHZ
)(
   input  wire logic                   CLK,
   input  wire logic                   RST_N,
   input  wire logic                   CE,
   input  wire logic                   SCL_I,
   output logic                        SCL_O,
   output logic                        SCL_OE,
   input  wire logic                   SDA_I,
   output logic                        SDA_O,
   output logic                        SDA_OE,
   input  wire logic                   INPUT_POWER_OK,
   input  wire logic                   STANDBY_LIVE,
   input  wire logic                   EEPROM_WP,
   input  wire logic [`SMBSE_EV_W-1:0] SHUTDOWN_EV,
   input  wire logic [`SMBSE_EV_W-1:0] WARNING_EV,
   output logic                        FAULT_ALERT_N,
   output smbse_rx_t                   CTL_RX,
   output smbse_end_t                  CTL_END,
   output smbse_rdreq_t                CTL_RD_REQ,
   input  wire smbse_rdrsp_t           CTL_RD_RSP
);
   localparam logic [`SMBSE_STRCNT_W-1:0] STR_LIM = `SMBSE_STRCNT_W'(STRETCH_CYC - 1);
   localparam logic [`SMBSE_LOWCNT_W-1:0] TO_LIM  = `SMBSE_LOWCNT_W'(TIMEOUT_CYC);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [`SMBSE_SYNC_W-1:0] sy1_q, sy2_q, sy3_q, filt_q, prev_q;
   wire  [`SMBSE_SYNC_W-1:0] raw_pins = {SCL_I, SDA_I, INPUT_POWER_OK, STANDBY_LIVE, EEPROM_WP};
   wire  [`SMBSE_SYNC_W-1:0] agree    = ~(sy2_q ^ sy3_q);
   wire  [`SMBSE_SYNC_W-1:0] filt_d   = (agree & sy3_q) | (~agree & filt_q);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sy1_q  <= `SMBSE_SYNC_RST;
         sy2_q  <= `SMBSE_SYNC_RST;
         sy3_q  <= `SMBSE_SYNC_RST;
         filt_q <= `SMBSE_SYNC_RST;
         prev_q <= `SMBSE_SYNC_RST;
      end else if (CE) begin
         sy1_q  <= raw_pins;
         sy2_q  <= sy1_q;
         sy3_q  <= sy2_q;
         filt_q <= filt_d;
         prev_q <= filt_q;
      end
   end

   // ****************************************
   // Bus conditions
   // ****************************************
   wire scl      = filt_q[`SMBSE_SY_SCL];
   wire sda      = filt_q[`SMBSE_SY_SDA];
   wire scl_p    = prev_q[`SMBSE_SY_SCL];
   wire sda_p    = prev_q[`SMBSE_SY_SDA];
   wire wp       = filt_q[`SMBSE_SY_WP];
   wire comm_en  = filt_q[`SMBSE_SY_PWR] | filt_q[`SMBSE_SY_STBY];
   wire scl_rise = scl & ~scl_p;
   wire scl_fall = ~scl & scl_p;
   wire bus_start = scl & scl_p & sda_p & ~sda;
   wire bus_stop  = scl & scl_p & ~sda_p & sda;

   // ****************************************
   // State
   // ****************************************
   smbse_state_t              state_q, state_d;
   smbse_tgt_t                tgt_q, tgt_d;
   logic [3:0]                bit_q, bit_d;
   logic [7:0]                shift_q, shift_d;
   logic [7:0]                tx_q, tx_d;
   logic [7:0]                cnt_q, cnt_d;
   logic [`SMBSE_MEM_AW-1:0]  ptr_q, ptr_d;
   logic                      rw_q, rw_d;
   logic                      off_q, off_d;
   logic                      first_q, first_d;
   logic                      sda_oe_q, sda_oe_d;
   logic                      scl_oe_q, scl_oe_d;
   logic [`SMBSE_LOWCNT_W-1:0] low_q, low_d;
   logic [`SMBSE_STRCNT_W-1:0] str_q, str_d;
   smbse_rx_t                 rx_q, rx_d;
   smbse_end_t                end_q, end_d;
   smbse_rdreq_t              req_q, req_d;
   logic                      alert_n_q;
   logic                      mem_we, mem_re;
   logic [7:0]                mem_rdata;

   // ****************************************
   // Address decode
   // ****************************************
   wire [7:0] addr_byte = {shift_q[7:1], 1'b0};
   wire hit_ctl  = (addr_byte == `SMBSE_CTL_ADDR);
   wire hit_ee   = ((addr_byte & `SMBSE_EE_MASK) == `SMBSE_EE_ADDR);
   wire byte_end = scl_fall && (bit_q == `SMBSE_BYTE_BITS);
   wire cnt_full = (cnt_q == `SMBSE_MAX_LEN);
   wire timeout  = (low_q == TO_LIM);
   wire str_out  = (str_q == STR_LIM);

   // ****************************************
   // Protocol engine
   // ****************************************
   always_comb begin
      state_d  = state_q;
      tgt_d    = tgt_q;
      bit_d    = bit_q;
      shift_d  = shift_q;
      tx_d     = tx_q;
      cnt_d    = cnt_q;
      ptr_d    = ptr_q;
      rw_d     = rw_q;
      off_d    = off_q;
      first_d  = 1'b0;
      sda_oe_d = sda_oe_q;
      scl_oe_d = scl_oe_q;
      str_d    = str_q;
      rx_d     = '0;
      end_d    = '0;
      req_d    = '0;
      mem_we   = 1'b0;
      mem_re   = 1'b0;
      low_d    = (scl || state_q == ST_IDLE) ? '0 : low_q + 1'b1;
      case (state_q)
         ST_ADDR, ST_WR: begin
            if (scl_rise) begin
               shift_d = {shift_q[6:0], sda};
               bit_d   = bit_q + 4'h1;
            end
            if (byte_end) begin
               bit_d   = 4'h0;
               state_d = ST_SKIP;
               if (state_q == ST_ADDR) begin
                  rw_d  = shift_q[0];
                  cnt_d = 8'h00;
                  if (hit_ctl) begin
                     tgt_d    = SMBSE_TGT_CTL;
                     sda_oe_d = 1'b1;
                     state_d  = ST_ACK;
                  end else if (hit_ee) begin
                     tgt_d    = SMBSE_TGT_EE;
                     ptr_d[`SMBSE_MEM_AW-1:8] = shift_q[`SMBSE_BLK_HI:`SMBSE_BLK_LO];
                     off_d    = ~shift_q[0];
                     sda_oe_d = 1'b1;
                     state_d  = ST_ACK;
                  end
               end else if (tgt_q == SMBSE_TGT_CTL) begin
                  if (!cnt_full) begin
                     rx_d.strobe = 1'b1;
                     rx_d.is_cmd = (cnt_q == 8'h00);
                     rx_d.data   = shift_q;
                     cnt_d       = cnt_q + 8'h01;
                     sda_oe_d    = 1'b1;
                     state_d     = ST_ACK;
                  end
               end else if (off_q) begin
                  ptr_d[7:0] = shift_q;
                  off_d      = 1'b0;
                  sda_oe_d   = 1'b1;
                  state_d    = ST_ACK;
               end else if (!wp) begin
                  mem_we   = 1'b1;
                  ptr_d    = ptr_q + 1'b1;
                  sda_oe_d = 1'b1;
                  state_d  = ST_ACK;
               end
            end
         end
         ST_ACK: begin
            if (scl_fall) begin
               sda_oe_d = 1'b0;
               if (rw_q) begin
                  state_d  = ST_LOAD;
                  scl_oe_d = 1'b1;
                  first_d  = 1'b1;
                  str_d    = '0;
                  mem_re   = (tgt_q == SMBSE_TGT_EE);
                  req_d.strobe = (tgt_q == SMBSE_TGT_CTL) && !cnt_full;
                  req_d.index  = cnt_q;
               end else begin
                  state_d = ST_WR;
               end
            end
         end
         ST_LOAD: begin
            str_d = str_q + 1'b1;
            if (tgt_q == SMBSE_TGT_EE && !first_q) begin
               tx_d     = mem_rdata;
               ptr_d    = ptr_q + 1'b1;
               scl_oe_d = 1'b0;
            end else if (tgt_q == SMBSE_TGT_CTL && cnt_full) begin
               tx_d     = `SMBSE_FILL_BYTE;
               scl_oe_d = 1'b0;
            end else if (tgt_q == SMBSE_TGT_CTL && CTL_RD_RSP.valid) begin
               tx_d     = CTL_RD_RSP.data;
               scl_oe_d = 1'b0;
            end else if (str_out) begin
               tx_d     = `SMBSE_FILL_BYTE;
               scl_oe_d = 1'b0;
            end
            if (!scl_oe_d) begin
               state_d  = ST_RD;
               bit_d    = 4'h0;
               sda_oe_d = ~tx_d[7];
               if (!cnt_full) begin
                  cnt_d = cnt_q + 8'h01;
               end
            end
         end
         ST_RD: begin
            if (scl_fall) begin
               if (bit_q == `SMBSE_LAST_BIT) begin
                  sda_oe_d = 1'b0;
                  state_d  = ST_MACK;
               end else begin
                  tx_d     = {tx_q[6:0], 1'b0};
                  sda_oe_d = ~tx_q[6];
                  bit_d    = bit_q + 4'h1;
               end
            end
         end
         ST_MACK: begin
            if (scl_rise) begin
               state_d = sda ? ST_SKIP : ST_ACK;
            end
         end
         default: begin
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
         end
      endcase
      if (bus_stop && state_q != ST_IDLE) begin
         state_d  = ST_IDLE;
         sda_oe_d = 1'b0;
         scl_oe_d = 1'b0;
         end_d.strobe = (tgt_q == SMBSE_TGT_CTL) && !rw_q && (cnt_q != 8'h00);
         end_d.count  = cnt_q;
      end else if (bus_start && comm_en) begin
         state_d  = ST_ADDR;
         bit_d    = 4'h0;
         sda_oe_d = 1'b0;
         scl_oe_d = 1'b0;
      end
      if (timeout || !comm_en) begin
         state_d  = ST_IDLE;
         sda_oe_d = 1'b0;
         scl_oe_d = 1'b0;
         low_d    = '0;
         mem_we   = 1'b0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_q  <= ST_IDLE;
         tgt_q    <= SMBSE_TGT_CTL;
         bit_q    <= 4'h0;
         shift_q  <= 8'h00;
         tx_q     <= 8'h00;
         cnt_q    <= 8'h00;
         ptr_q    <= '0;
         rw_q     <= 1'b0;
         off_q    <= 1'b0;
         first_q  <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
         low_q    <= '0;
         str_q    <= '0;
         rx_q     <= '0;
         end_q    <= '0;
         req_q    <= '0;
      end else if (CE) begin
         state_q  <= state_d;
         tgt_q    <= tgt_d;
         bit_q    <= bit_d;
         shift_q  <= shift_d;
         tx_q     <= tx_d;
         cnt_q    <= cnt_d;
         ptr_q    <= ptr_d;
         rw_q     <= rw_d;
         off_q    <= off_d;
         first_q  <= first_d;
         sda_oe_q <= sda_oe_d;
         scl_oe_q <= scl_oe_d;
         low_q    <= low_d;
         str_q    <= str_d;
         rx_q     <= rx_d;
         end_q    <= end_d;
         req_q    <= req_d;
      end
   end

   // ****************************************
   // Alert
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         alert_n_q <= 1'b1;
      end else if (CE) begin
         alert_n_q <= ~(|SHUTDOWN_EV | |WARNING_EV);
      end
   end

   // ****************************************
   // User storage
   // ****************************************
   smbse_mem u_mem (
      .clk   (CLK),
      .rst_n (RST_N),
      .ce    (CE),
      .we    (mem_we && CE),
      .re    (mem_re),
      .addr  (ptr_q),
      .wdata (shift_q),
      .rdata (mem_rdata)
   );

   assign SCL_O         = 1'b0;
   assign SDA_O         = 1'b0;
   assign SCL_OE        = scl_oe_q;
   assign SDA_OE        = sda_oe_q;
   assign FAULT_ALERT_N = alert_n_q;
   assign CTL_RX        = rx_q;
   assign CTL_END       = end_q;
   assign CTL_RD_REQ    = req_q;
endmodule
`default_nettype wire

/* tb/smbse_host.sv */
`timescale 1ns/1ps
`default_nettype none
module smbse_host #(
   parameter int HALF = 200,
   parameter int GAP  = 200000
)(
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   output var logic  scl_oe,
   output var logic  sda_oe
);
   // *****
   // Bus master tasks
   // *****
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic go();
      sda_oe = 1'b1;
      hold(HALF);
      scl_oe = 1'b1;
   endtask
   task automatic bit_io(input logic b, output logic r);
      hold(20);
      sda_oe = !b;
      hold(HALF - 20);
      scl_oe = 1'b0;
      for (int k = 0; k < 4000 && !scl; k++) hold(1);
      hold(HALF / 2);
      r = sda;
      hold(HALF / 2);
      scl_oe = 1'b1;
   endtask
   task automatic rs();
      hold(20);
      sda_oe = 1'b0;
      hold(HALF);
      scl_oe = 1'b0;
      hold(HALF);
      go();
   endtask
   task automatic halt();
      hold(20);
      sda_oe = 1'b1;
      hold(HALF);
      scl_oe = 1'b0;
      hold(HALF);
      sda_oe = 1'b0;
      hold(HALF);
   endtask
   task automatic xb(input logic [7:0] d, input logic last, output logic [7:0] q,
                     output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(last, r);
      ack = !r;
   endtask
   task automatic nib(input logic [3:0] d);
      logic r;
      for (int i = 3; i >= 0; i--) bit_io(d[i], r);
   endtask
   task automatic gap();
      hold(GAP);
   endtask
endmodule
`default_nettype wire

/* tb/smbse_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smbse_params.svh"
module smbse_properties
   import smbse_pkg::*;
#(
   parameter int STRETCH_CYC = 40000,
   parameter int TIMEOUT_CYC = 1000000
)(
   input wire logic                   CLK,
   input wire logic                   RST_N,
   input wire logic                   CE,
   input wire logic                   SCL_I,
   input wire logic                   SCL_OE,
   input wire logic                   SDA_I,
   input wire logic                   SDA_OE,
   input wire logic                   INPUT_POWER_OK,
   input wire logic                   STANDBY_LIVE,
   input wire logic [`SMBSE_EV_W-1:0] SHUTDOWN_EV,
   input wire logic [`SMBSE_EV_W-1:0] WARNING_EV,
   input wire logic                   FAULT_ALERT_N,
   input wire smbse_rx_t              CTL_RX,
   input wire smbse_end_t             CTL_END,
   input wire smbse_rdreq_t           CTL_RD_REQ,
   input wire smbse_rdrsp_t           CTL_RD_RSP
);
   // *****
   // Run lengths
   // *****
   int  str_q;
   int  low_q;
   wire ev_any = (|SHUTDOWN_EV) || (|WARNING_EV);
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         str_q <= 0;
         low_q <= 0;
      end else begin
         str_q <= SCL_OE ? str_q + 1 : 0;
         low_q <= SCL_I ? 0 : low_q + 1;
      end
   end
   // *****
   // Properties
   // *****
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_unpowered;
      !INPUT_POWER_OK && !STANDBY_LIVE;
   endsequence
   sequence s_answered;
      SCL_OE && CTL_RD_RSP.valid;
   endsequence
   a_alert_is_or: assert property (CE |=> FAULT_ALERT_N == !$past(ev_any))
      else $error("alert does not follow events");
   a_freeze_hold: assert property (!CE |=> $stable(FAULT_ALERT_N))
      else $error("alert moved while clock enable low");
   a_no_start_made: assert property (!$stable(SDA_OE) |-> !SCL_I)
      else $error("data line moved while clock high");
   a_stretch_bound: assert property (str_q <= STRETCH_CYC + 4)
      else $error("clock stretch too long");
   a_timeout_release: assert property (low_q > TIMEOUT_CYC + 16 |-> !SDA_OE && !SCL_OE)
      else $error("lines held after clock low timeout");
   a_quiet_unpowered: assert property (s_unpowered [*8] |-> !SDA_OE && !SCL_OE)
      else $error("bus answered without power");
   a_rx_on_ack: assert property (CTL_RX.strobe |-> SDA_OE)
      else $error("byte passed on without acknowledge");
   a_rx_one_pulse: assert property (CTL_RX.strobe |=> !CTL_RX.strobe)
      else $error("byte strobe longer than one cycle");
   a_end_on_stop: assert property ($rose(CTL_END.strobe) |-> SCL_I && SDA_I
      && CTL_END.count != 8'h00) else $error("write end without stop");
   a_rdreq_stretch: assert property (CTL_RD_REQ.strobe |-> SCL_OE)
      else $error("read fetch without stretch");
   a_answer_release: assert property (s_answered |=> !SCL_OE)
      else $error("stretch kept after answer");
endmodule
bind smbse_top smbse_properties #(.STRETCH_CYC(STRETCH_CYC), .TIMEOUT_CYC(TIMEOUT_CYC))
   smbse_properties_i (.CLK, .RST_N, .CE, .SCL_I, .SCL_OE, .SDA_I, .SDA_OE, .INPUT_POWER_OK,
   .STANDBY_LIVE, .SHUTDOWN_EV, .WARNING_EV, .FAULT_ALERT_N, .CTL_RX, .CTL_END,
   .CTL_RD_REQ, .CTL_RD_RSP);
`default_nettype wire

/* tb/smbus_slave_with_eeprom_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_with_eeprom_bench
   import smbse_pkg::*;
;
   // *****
   // Bench
   // *****
   localparam int STR  = 50;
   localparam int TOUT = 400;
   logic         clk, rst_n, pwr_ok, stby, wp, scl_oe, sda_oe, h_scl_oe, h_sda_oe, alert_n, a;
   logic         ce, scl_o, sda_o;
   logic [7:0]   sd_ev, wn_ev, q, off, cmd, v1, v2, rdv, end_cnt, last_idx;
   smbse_rx_t    rx;
   smbse_end_t   fin;
   smbse_rdreq_t req;
   smbse_rdrsp_t rsp;
   wire          scl = !(scl_oe || h_scl_oe);
   wire          sda = !(sda_oe || h_sda_oe);
   int           seed = 32'hE114ACF2;
   int           num_errors = 0;
   int           num_checks = 0;
   int           cyc = 0;
   int           pend = 0;
   int           n;
   logic [8:0]   rxq[$];
   smbse_top #(.STRETCH_CYC(STR), .TIMEOUT_CYC(TOUT)) smbse_top_i (
      .CLK(clk), .RST_N(rst_n), .CE(ce), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .INPUT_POWER_OK(pwr_ok), .STANDBY_LIVE(stby),
      .EEPROM_WP(wp), .SHUTDOWN_EV(sd_ev), .WARNING_EV(wn_ev), .FAULT_ALERT_N(alert_n),
      .CTL_RX(rx), .CTL_END(fin), .CTL_RD_REQ(req), .CTL_RD_RSP(rsp));
   smbse_host #(.GAP(800)) smbse_host_i (.clk(clk), .scl(scl), .sda(sda),
      .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));
   function automatic logic hit(input logic [7:0] ad, input logic up);
      return up && (ad[7:1] == 7'h10 || ad[7:4] == 4'hA);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] d, input logic ack_exp);
      smbse_host_i.xb(d, 1'b1, q, a);
      chk(16'(a), 16'(ack_exp));
   endtask
   task automatic rd(input logic last, input logic [7:0] exp);
      smbse_host_i.xb(8'hFF, last, q, a);
      chk(16'(q), 16'(exp));
   endtask
   task automatic probe(input logic [7:0] ad);
      smbse_host_i.go();
      wr(ad, hit(ad, pwr_ok || stby));
      smbse_host_i.halt();
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = !clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 120000) begin
         num_errors++;
         final_report();
      end
   end
   always @(negedge clk) begin
      if (rx.strobe) rxq.push_back({rx.is_cmd, rx.data});
      if (fin.strobe) end_cnt = fin.count;
      if (req.strobe) last_idx = req.index;
      if (req.strobe && req.index == 8'h00) pend = 2;
      rsp <= (pend > 0) ? {1'b1, rdv} : 9'h000;
      if (pend > 0) pend--;
   end
   initial begin
      {rst_n, pwr_ok, stby, wp, ce, sd_ev, wn_ev, rdv} = {5'h09, 24'h000000};
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      for (int i = 0; i < 16; i++) begin
         sd_ev = (i % 3 == 0) ? 8'($random(seed)) : 8'h00;
         wn_ev = (i % 2 == 0) ? 8'h00 : 8'($random(seed));
         repeat (2) @(negedge clk);
         chk(16'(alert_n), 16'((sd_ev | wn_ev) == 8'h00));
      end
      sd_ev = 8'h01;
      repeat (2) @(negedge clk);
      ce = 1'b0;
      sd_ev = 8'h00;
      wn_ev = 8'h00;
      repeat (3) @(negedge clk);
      chk(16'(alert_n), 16'h0000);
      ce = 1'b1;
      repeat (2) @(negedge clk);
      chk(16'(alert_n), 16'h0001);
      $display("alert test done");
      {v1, off} = 16'($random(seed));
      v2 = ~v1;
      smbse_host_i.go();
      wr(8'hA6, 1'b1);
      wr(off, 1'b1);
      wr(v1, 1'b1);
      smbse_host_i.halt();
      smbse_host_i.gap();
      wp = 1'b1;
      smbse_host_i.go();
      wr(8'hA6, 1'b1);
      wr(off, 1'b1);
      wr(v2, 1'b0);
      smbse_host_i.halt();
      smbse_host_i.gap();
      smbse_host_i.go();
      wr(8'hA6, 1'b1);
      wr(off, 1'b1);
      smbse_host_i.rs();
      wr(8'hA7, 1'b1);
      rd(1'b1, v1);
      smbse_host_i.halt();
      $display("memory test done");
      {pwr_ok, stby} = 2'b00;
      repeat (8) @(negedge clk);
      probe(8'h20);
      stby = 1'b1;
      repeat (8) @(negedge clk);
      probe(8'h50);
      {cmd, v1, v2} = 24'($random(seed));
      rxq.delete();
      smbse_host_i.go();
      smbse_host_i.nib(4'hA);
      smbse_host_i.rs();
      wr(8'h20, 1'b1);
      wr(cmd, 1'b1);
      wr(v1, 1'b1);
      wr(v2, 1'b1);
      smbse_host_i.halt();
      repeat (20) @(negedge clk);
      chk(16'(rxq.size()), 16'h0003);
      chk(16'(rxq[0]), {7'h00, 1'b1, cmd});
      chk(16'(rxq[1]), {8'h00, v1});
      chk(16'(rxq[2]), {8'h00, v2});
      chk(16'(end_cnt), 16'h0003);
      $display("command write test done");
      rdv = 8'($random(seed));
      smbse_host_i.go();
      wr(8'h20, 1'b1);
      wr(cmd, 1'b1);
      smbse_host_i.rs();
      wr(8'h21, 1'b1);
      rd(1'b0, rdv);
      rd(1'b1, 8'hFF);
      smbse_host_i.halt();
      chk(16'(last_idx), 16'h0001);
      $display("command read test done");
      smbse_host_i.go();
      wr(8'h20, 1'b1);
      repeat (TOUT + 100) @(negedge clk);
      chk(16'({scl_oe, sda_oe}), 16'h0000);
      n = rxq.size();
      wr(cmd, 1'b0);
      chk(16'(rxq.size()), 16'(n));
      smbse_host_i.halt();
      $display("timeout test done");
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      probe(8'hA0);
      chk(16'({scl_o, sda_o}), 16'h0000);
      $display("reset test done");
      final_report();
   end
endmodule
`default_nettype wire
